//--- design/cca_counter_array.sv
module cca_counter_array
	import cca_pkg::*;
#(
	parameter int NUM_MODULES = 3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor status
	input wire logic global_irq_enable,
	input wire logic array_irq_enable,
	input wire logic cpu_idle,
	// Tick sources
	input wire logic timer0_overflow,
	input wire logic external_count_input,
	input wire logic external_osc,
	// Module pins
	input wire logic [NUM_MODULES-1:0] module_pin_in,
	output logic [NUM_MODULES-1:0] module_pin_out,
	output logic [NUM_MODULES-1:0] module_pin_oe,
	// Interrupt request
	output logic irq_request
);

	// ==========================================================
	// Register state
	logic [7:0] array_mode_register; // Array mode bits
	logic counter_overflow_flag; // Sticky wrap flag
	logic [NUM_MODULES-1:0] module_event_flag; // Sticky module flags
	logic [15:0] count; // Live counter
	logic [7:0] snapshot; // High byte latched on low read
	logic [7:0] module_mode_register [NUM_MODULES]; // Per module mode
	logic [15:0] compare [NUM_MODULES]; // Per module compare/capture
	logic [NUM_MODULES-1:0] capture_ev; // Capture pulses
	logic [NUM_MODULES-1:0] match_ev; // Match pulses
	logic count_moved; // Counter stepped last cycle

	// Decoded fields
	logic watchdog_on;
	logic [2:0] timebase_select;
	assign watchdog_on = array_mode_register[CCA_AM_WATCHDOG];
	assign timebase_select = array_mode_register[CCA_AM_TB_LSB +: 3];

	// ==========================================================
	// APB decode; zero wait state, answer in first access cycle
	logic setup_ph;
	logic wr_acc;
	logic [3:0] sel_idx; // Word index within block
	logic [1:0] mod_idx; // Module number for module banks
	logic mod_ok;
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pready & pwrite;
	assign sel_idx = paddr[5:2];
	assign mod_idx = paddr[3:2];
	assign mod_ok = (32'(mod_idx) < NUM_MODULES) && (paddr[1:0] == 2'b00);

	// Address lands on a real register
	logic addr_hit;
	always_comb begin
		addr_hit = 1'b0;
		if (paddr[1:0] == 2'b00 && paddr[7:6] == 2'b00) begin
			if (sel_idx < 4'h4) begin
				addr_hit = 1'b1;
			end else begin
				addr_hit = mod_ok; // Module banks, compare high included
			end
		end
	end

	// Read mux, sampled at setup for a stable answer
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (paddr == CCA_ADDR_ARRAY_MODE) begin
			rd_byte = array_mode_register;
		end else if (paddr == CCA_ADDR_ARRAY_CONTROL) begin
			rd_byte = 8'h00;
			rd_byte[CCA_AC_OVF_FLAG] = counter_overflow_flag;
			rd_byte[NUM_MODULES-1:0] = module_event_flag;
		end else if (paddr == CCA_ADDR_COUNTER_LOW) begin
			rd_byte = count[7:0];
		end else if (paddr == CCA_ADDR_COUNTER_HIGH) begin
			rd_byte = snapshot;
		end else if (mod_ok && paddr[7:4] == CCA_ADDR_MODULE_MODE[7:4]) begin
			rd_byte = module_mode_register[mod_idx];
		end else if (mod_ok && paddr[7:4] == CCA_ADDR_COMPARE_LOW[7:4]) begin
			rd_byte = compare[mod_idx][7:0];
		end else if (mod_ok && paddr[7:4] == CCA_ADDR_COMPARE_HIGH[7:4]) begin
			rd_byte = compare[mod_idx][15:8];
		end
	end

	// Bus answer flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_ph;
			if (setup_ph) begin
				prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
				pslverr <= ~addr_hit;
			end
		end
	end

	// Snapshot latch on low read; same count as the returned low byte
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			snapshot <= 8'h00;
		end else if (setup_ph && !pwrite && paddr == CCA_ADDR_COUNTER_LOW) begin
			snapshot <= count[15:8];
		end
	end

	// ==========================================================
	// Array mode register; watchdog freezes timebase and idle bits
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			array_mode_register <= CCA_AM_RESET;
		end else if (wr_acc && paddr == CCA_ADDR_ARRAY_MODE) begin
			if (watchdog_on) begin
				array_mode_register[CCA_AM_OVF_IRQ_EN] <= pwdata[CCA_AM_OVF_IRQ_EN];
				array_mode_register[CCA_AM_WATCHDOG] <= pwdata[CCA_AM_WATCHDOG];
			end else begin
				array_mode_register <= pwdata[7:0] & 8'hCF;
			end
		end
	end

	// ==========================================================
	// Tick sources; all edges seen in the core clock domain
	logic [3:0] div12_cnt;
	logic [3:0] div4_cnt;
	logic [3:0] osc_cnt;
	logic eci_prev;
	logic osc_sync1;
	logic osc_sync2;
	logic osc_prev;
	logic osc_tick;

	// Free dividers for clock/12 and clock/4
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			div12_cnt <= 4'h0;
			div4_cnt <= 4'h0;
		end else begin
			div12_cnt <= (div12_cnt == CCA_DIV12_COUNT - 4'h1) ? 4'h0 : div12_cnt + 4'h1;
			div4_cnt <= (div4_cnt == CCA_DIV4_COUNT - 4'h1) ? 4'h0 : div4_cnt + 4'h1;
		end
	end

	// Oscillator crosses in by two flops, then divides by eight
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_sync1 <= 1'b0;
			osc_sync2 <= 1'b0;
			osc_prev <= 1'b0;
			osc_cnt <= 4'h0;
			osc_tick <= 1'b0;
		end else begin
			osc_sync1 <= external_osc;
			osc_sync2 <= osc_sync1;
			osc_prev <= osc_sync2;
			osc_tick <= 1'b0;
			if (osc_sync2 && !osc_prev) begin
				if (osc_cnt == CCA_DIV8_COUNT - 4'h1) begin
					osc_cnt <= 4'h0;
					osc_tick <= 1'b1;
				end else begin
					osc_cnt <= osc_cnt + 4'h1;
				end
			end
		end
	end

	// External count input is synchronous; keep last level
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			eci_prev <= 1'b1;
		end else begin
			eci_prev <= external_count_input;
		end
	end

	// Timebase mux; reserved codes never tick
	logic tick;
	always_comb begin
		unique case (timebase_select)
			CCA_TB_DIV12: tick = (div12_cnt == 4'h0);
			CCA_TB_DIV4: tick = (div4_cnt == 4'h0);
			CCA_TB_TIMER0: tick = timer0_overflow;
			CCA_TB_EXT_EDGE: tick = eci_prev & ~external_count_input;
			CCA_TB_SYSCLK: tick = 1'b1;
			CCA_TB_OSC_DIV8: tick = osc_tick;
			default: tick = 1'b0;
		endcase
	end

	// Idle suspend gates the counter tick; captures still run
	logic run_en;
	logic step;
	assign run_en = ~(cpu_idle & array_mode_register[CCA_AM_IDLE_SUSPEND]);
	assign step = tick & run_en;

	// ==========================================================
	// Counter; reads never touch it, writes blocked under watchdog
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 16'h0000;
			count_moved <= 1'b0;
		end else begin
			count_moved <= step;
			if (wr_acc && !watchdog_on && paddr == CCA_ADDR_COUNTER_LOW) begin
				count[7:0] <= pwdata[7:0];
			end else if (wr_acc && !watchdog_on && paddr == CCA_ADDR_COUNTER_HIGH) begin
				count[15:8] <= pwdata[7:0];
			end else if (step) begin
				count <= count + 16'h0001;
			end
		end
	end

	// Wrap detect; a counter write in the same cycle wins, so no wrap
	logic cnt_wr;
	logic wrap_ev;
	assign cnt_wr = wr_acc && !watchdog_on && (paddr == CCA_ADDR_COUNTER_LOW || paddr == CCA_ADDR_COUNTER_HIGH);
	assign wrap_ev = step & ~cnt_wr & (count == CCA_COUNT_MAX);

	// ==========================================================
	// Sticky flags; a same-cycle set beats a software clear
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			counter_overflow_flag <= 1'b0;
			module_event_flag <= '0;
		end else begin
			if (wrap_ev) begin
				counter_overflow_flag <= 1'b1;
			end else if (wr_acc && paddr == CCA_ADDR_ARRAY_CONTROL && !pwdata[CCA_AC_OVF_FLAG]) begin
				counter_overflow_flag <= 1'b0;
			end
			for (int i = 0; i < NUM_MODULES; i++) begin
				if (capture_ev[i] || match_ev[i]) begin
					module_event_flag[i] <= 1'b1;
				end else if (wr_acc && paddr == CCA_ADDR_ARRAY_CONTROL && !pwdata[i]) begin
					module_event_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Interrupt request from flags and enables
	logic [NUM_MODULES-1:0] mod_irq_en;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= global_irq_enable & array_irq_enable &
				((counter_overflow_flag & array_mode_register[CCA_AM_OVF_IRQ_EN]) |
				(|(module_event_flag & mod_irq_en)));
		end
	end

	// ==========================================================
	// Capture/compare modules
	genvar g;
	generate
		for (g = 0; g < NUM_MODULES; g++) begin : gen_mod
			logic [7:0] mm;
			logic pin_prev;
			logic rise;
			logic fall;
			logic wr_mode;
			logic wr_low;
			logic wr_high;
			cca_mode_t mode;
			assign mm = module_mode_register[g];
			assign mod_irq_en[g] = mm[CCA_MM_IRQ_EN];
			assign rise = module_pin_in[g] & ~pin_prev;
			assign fall = ~module_pin_in[g] & pin_prev;
			assign wr_mode = wr_acc && paddr == CCA_ADDR_MODULE_MODE + 8'(4 * g);
			assign wr_low = wr_acc && paddr == CCA_ADDR_COMPARE_LOW + 8'(4 * g);
			assign wr_high = wr_acc && paddr == CCA_ADDR_COMPARE_HIGH + 8'(4 * g);

			// Mode decode
			always_comb begin
				mode = CCA_MODE_IDLE;
				if (!mm[CCA_MM_COMP_EN] && !mm[CCA_MM_MATCH] && !mm[CCA_MM_TOGGLE] && !mm[CCA_MM_PULSE]) begin
					if (mm[CCA_MM_RISE_CAP] || mm[CCA_MM_FALL_CAP]) begin
						mode = CCA_MODE_CAPTURE;
					end
				end else if (mm[CCA_MM_COMP_EN] && !mm[CCA_MM_RISE_CAP] && !mm[CCA_MM_FALL_CAP]) begin
					if (mm[CCA_MM_PULSE]) begin
						mode = mm[CCA_MM_TOGGLE] ? CCA_MODE_FREQ_OUT :
							(mm[CCA_MM_WIDE] ? CCA_MODE_PWM16 : CCA_MODE_PWM8);
					end else if (mm[CCA_MM_MATCH]) begin
						mode = mm[CCA_MM_TOGGLE] ? CCA_MODE_HS_OUT : CCA_MODE_SW_TIMER;
					end
				end
			end

			// Pin history; two-clock levels keep edges visible
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					pin_prev <= 1'b0;
				end else begin
					pin_prev <= module_pin_in[g];
				end
			end

			// Events: capture on chosen edge, match once per count value
			assign capture_ev[g] = (mode == CCA_MODE_CAPTURE) &&
				((rise && mm[CCA_MM_RISE_CAP]) || (fall && mm[CCA_MM_FALL_CAP]));
			assign match_ev[g] = count_moved && (count == compare[g]) &&
				(mode == CCA_MODE_SW_TIMER || mode == CCA_MODE_HS_OUT);

			// Mode register; comparator bit forced by compare writes
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					module_mode_register[g] <= CCA_MM_RESET;
				end else if (wr_low) begin
					module_mode_register[g][CCA_MM_COMP_EN] <= 1'b0;
				end else if (wr_high) begin
					module_mode_register[g][CCA_MM_COMP_EN] <= 1'b1;
				end else if (wr_mode && !(g == 2 && watchdog_on)) begin
					module_mode_register[g] <= pwdata[7:0];
				end
			end

			// Compare/capture bytes; capture takes the whole counter
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					compare[g] <= 16'h0000;
				end else if (capture_ev[g]) begin
					compare[g] <= count;
				end else if (wr_low) begin
					compare[g][7:0] <= pwdata[7:0];
				end else if (wr_high) begin
					compare[g][15:8] <= pwdata[7:0];
				end
			end

			// Pin drive; only high-speed output mode owns the pin
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					module_pin_out[g] <= 1'b0;
					module_pin_oe[g] <= 1'b0;
				end else begin
					module_pin_oe[g] <= (mode == CCA_MODE_HS_OUT);
					if (match_ev[g] && mode == CCA_MODE_HS_OUT) begin
						module_pin_out[g] <= ~module_pin_out[g];
					end
				end
			end

			// Checks for this module
			AST_CAPTURE_COPIES: assert property (@(posedge core_clk) disable iff (!reset_n)
				capture_ev[g] |=> (compare[g] == $past(count)))
				else $error("capture did not copy counter");
			AST_CAPTURE_FLAGS: assert property (@(posedge core_clk) disable iff (!reset_n)
				capture_ev[g] |=> module_event_flag[g])
				else $error("capture flag not set");
			AST_LOW_CLEARS_COMP: assert property (@(posedge core_clk) disable iff (!reset_n)
				wr_low |=> !module_mode_register[g][CCA_MM_COMP_EN])
				else $error("compare low write left comparator on");
			AST_HSO_TOGGLE: assert property (@(posedge core_clk) disable iff (!reset_n)
				(match_ev[g] && mode == CCA_MODE_HS_OUT) |=> (module_pin_out[g] != $past(module_pin_out[g])))
				else $error("pin did not toggle on match");
		end
	endgenerate

	// ==========================================================
	// Array-level checks
	AST_WRAP_SETS_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n)
		(step && !cnt_wr && count == 16'hFFFF) |=> (counter_overflow_flag && count == 16'h0000))
		else $error("wrap did not set overflow flag");
	AST_FLAG_HOLDS: assert property (@(posedge core_clk) disable iff (!reset_n)
		(counter_overflow_flag && !(wr_acc && paddr == CCA_ADDR_ARRAY_CONTROL)) |=> counter_overflow_flag)
		else $error("overflow flag dropped without write");
	AST_IRQ_GATED: assert property (@(posedge core_clk) disable iff (!reset_n)
		!(global_irq_enable && array_irq_enable) |=> !irq_request)
		else $error("interrupt without global enables");
	AST_STEP_ONE: assert property (@(posedge core_clk) disable iff (!reset_n)
		(step && !wr_acc) |=> (count == $past(count) + 16'h0001))
		else $error("counter did not step by one");
	AST_IDLE_HOLDS: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_idle && array_mode_register[CCA_AM_IDLE_SUSPEND] && !wr_acc) |=> $stable(count))
		else $error("counter moved while suspended");
	AST_SNAPSHOT: assert property (@(posedge core_clk) disable iff (!reset_n)
		(setup_ph && !pwrite && paddr == CCA_ADDR_COUNTER_LOW) |=> (snapshot == $past(count[15:8])))
		else $error("snapshot not latched");
	AST_WDOG_BLOCK: assert property (@(posedge core_clk) disable iff (!reset_n)
		(watchdog_on && !step && wr_acc && paddr == CCA_ADDR_COUNTER_HIGH) |=> $stable(count))
		else $error("counter written under watchdog");

endmodule

//--- design/cca_pkg.sv
// Function
// - One 16-bit counter, three capture/compare modules
// - Low byte read latches high byte snapshot
// - Counter reads never disturb counting
// - Timebase select picks one of six tick sources
// - Oscillator/8 tick synchronised; oscillator not faster
// - Counter wrap sets overflow flag, optional interrupt
// - Overflow flag cleared only by software zero
// - Interrupts need global and array enables
// - Idle suspend stops the counter during idle; captures still run
// - Capture edge type from rising/falling enables
// - Mode decode from comparator/match/toggle/pulse bits
// - Module interrupt enable gates module event flag
// - Capture copies full counter into compare bytes
// - Capture sets sticky module event flag
// - Software timer match sets module event flag
// - Compare low write clears, high write sets comparator
// - High-speed output toggles pin on match
// - Module two comes up as watchdog after reset
// - Watchdog on: counter byte writes ignored
package cca_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] CCA_ADDR_ARRAY_MODE = 8'h00;
	localparam logic [7:0] CCA_ADDR_ARRAY_CONTROL = 8'h04;
	localparam logic [7:0] CCA_ADDR_COUNTER_LOW = 8'h08;
	localparam logic [7:0] CCA_ADDR_COUNTER_HIGH = 8'h0C;
	localparam logic [7:0] CCA_ADDR_MODULE_MODE = 8'h10; // Plus 4 per module
	localparam logic [7:0] CCA_ADDR_COMPARE_LOW = 8'h20; // Plus 4 per module
	localparam logic [7:0] CCA_ADDR_COMPARE_HIGH = 8'h30; // Plus 4 per module

	// ==========================================================
	// Array mode register fields
	localparam int CCA_AM_OVF_IRQ_EN = 0;
	localparam int CCA_AM_TB_LSB = 1;
	localparam int CCA_AM_WATCHDOG = 6;
	localparam int CCA_AM_IDLE_SUSPEND = 7;
	localparam logic [7:0] CCA_AM_RESET = 8'h40; // Watchdog on, clock/12

	// Array control register fields
	localparam int CCA_AC_OVF_FLAG = 7;

	// ==========================================================
	// Module mode register fields
	localparam int CCA_MM_IRQ_EN = 0;
	localparam int CCA_MM_PULSE = 1;
	localparam int CCA_MM_TOGGLE = 2;
	localparam int CCA_MM_MATCH = 3;
	localparam int CCA_MM_FALL_CAP = 4;
	localparam int CCA_MM_RISE_CAP = 5;
	localparam int CCA_MM_COMP_EN = 6;
	localparam int CCA_MM_WIDE = 7;
	localparam logic [7:0] CCA_MM_RESET = 8'h00;

	// ==========================================================
	// Timebase codes
	typedef enum logic [2:0] {
		CCA_TB_DIV12 = 3'b000,
		CCA_TB_DIV4 = 3'b001,
		CCA_TB_TIMER0 = 3'b010,
		CCA_TB_EXT_EDGE = 3'b011,
		CCA_TB_SYSCLK = 3'b100,
		CCA_TB_OSC_DIV8 = 3'b101
	} cca_timebase_t;

	// Module operating modes after decode
	typedef enum logic [2:0] {
		CCA_MODE_IDLE = 3'b000,
		CCA_MODE_CAPTURE = 3'b001,
		CCA_MODE_SW_TIMER = 3'b010,
		CCA_MODE_HS_OUT = 3'b011,
		CCA_MODE_FREQ_OUT = 3'b100,
		CCA_MODE_PWM8 = 3'b101,
		CCA_MODE_PWM16 = 3'b110
	} cca_mode_t;

	// ==========================================================
	// Divider counts
	localparam logic [3:0] CCA_DIV12_COUNT = 4'hC;
	localparam logic [3:0] CCA_DIV4_COUNT = 4'h4;
	localparam logic [3:0] CCA_DIV8_COUNT = 4'h8;
	localparam logic [15:0] CCA_COUNT_MAX = 16'hFFFF;

endpackage

//--- sim/cca_pin_source.sv
// ==========
// External pulse sources on the far side
module cca_pin_source (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Pin levels asked for by the bench
	input wire logic [2:0] want_pin,
	// Driven sources
	output logic [2:0] src_pin,
	output logic timer0_overflow,
	output logic external_count_input,
	output logic external_osc
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] cyc; // Ten-cycle cadence
	logic slot; // Pin update slot

	// Oscillator at one third of core rate, own phase
	initial begin
		external_osc = 1'b0;
		#1;
		forever #6 external_osc = ~external_osc;
	end

	// Pins move every other cycle, so each level lasts two clocks
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cyc <= 4'h0;
			slot <= 1'b0;
			src_pin <= 3'h0;
			timer0_overflow <= 1'b0;
			external_count_input <= 1'b1;
		end else begin
			cyc <= (cyc == 4'h9) ? 4'h0 : cyc + 4'h1;
			slot <= ~slot;
			if (slot) begin
				src_pin <= want_pin;
			end
			timer0_overflow <= (cyc == 4'h4) || (cyc == 4'h9);
			external_count_input <= (cyc < 4'h5);
		end
	end
endmodule

//--- sim/counter_array_capture_compare_bench.sv
// ==========
// Self-checking bench
module counter_array_capture_compare_bench import cca_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk, reset_n, psel, penable, pwrite;
	logic global_irq_enable, array_irq_enable, cpu_idle, irq_request;
	logic pready, pslverr, slverr, timer0_overflow, external_count_input, external_osc;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [2:0] want_pin, src_pin, pin_wire, pin_out, pin_oe;
	logic [15:0] v1, v2, cap;
	logic [7:0] mode;
	logic lvl;
	int error_cnt, samples_checked, cycles;

	// Wire level: module drives while enabled, else the source
	assign pin_wire = (pin_oe & pin_out) | (~pin_oe & src_pin);

	cca_counter_array #(.NUM_MODULES(3)) uut (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
		.array_irq_enable(array_irq_enable), .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
		.external_count_input(external_count_input), .external_osc(external_osc),
		.module_pin_in(pin_wire), .module_pin_out(pin_out), .module_pin_oe(pin_oe),
		.irq_request(irq_request));

	cca_pin_source src (.core_clk(core_clk), .reset_n(reset_n), .want_pin(want_pin), .src_pin(src_pin),
		.timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
		.external_osc(external_osc));

	// ==========
	// Clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	// ==========
	// Helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer: setup, access, hold until pready
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= {24'h00_0000, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Low first, so the high byte comes from the snapshot
	task automatic rdcnt(output logic [15:0] v);
		apb(1'b0, CCA_ADDR_COUNTER_LOW, 8'h00);
		v[7:0] = rd[7:0];
		apb(1'b0, CCA_ADDR_COUNTER_HIGH, 8'h00);
		v[15:8] = rd[7:0];
	endtask

	function automatic logic [15:0] ticks(input int code, input int span);
		case (code)
			0: return 16'(span / 12);
			1: return 16'(span / 4);
			2: return 16'(span / 5);
			3: return 16'(span / 10);
			4: return 16'(span);
			default: return 16'(span / 24);
		endcase
	endfunction

	// Edge phases of the sources allow a slack of two
	function automatic logic near(input logic [15:0] a, input logic [15:0] b);
		return (a + 16'h0002 >= b) && (a <= b + 16'h0002);
	endfunction

	function automatic logic [7:0] at(input logic [7:0] base, input int n);
		return base + 8'(4 * n);
	endfunction

	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{global_irq_enable, array_irq_enable, cpu_idle, want_pin} = '0;
		reset_n = 1'b0;
		error_cnt = 0;
		samples_checked = 0;
		cycles = 0;
		seed = 32'h712c_c45a;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		// Watchdog owns the array after reset
		apb(1'b0, CCA_ADDR_ARRAY_MODE, 8'h00);
		check(rd[15:0], {8'h00, CCA_AM_RESET});
		apb(1'b1, CCA_ADDR_COUNTER_HIGH, 8'hAA);
		rdcnt(v1);
		check({8'h00, v1[15:8]}, 16'h0000);
		apb(1'b1, CCA_ADDR_ARRAY_MODE, 8'h48);
		apb(1'b0, CCA_ADDR_ARRAY_MODE, 8'h00);
		check(rd[15:0], 16'h0040);
		// Unmapped place
		apb(1'b0, 8'hFC, 8'h00);
		check({slverr, rd[14:0]}, 16'h8000);
		// Watchdog off, full-rate ticks; reads must not disturb
		// Timebase stays frozen on the write that ends the watchdog, so write twice
		apb(1'b1, CCA_ADDR_ARRAY_MODE, 8'h08);
		apb(1'b1, CCA_ADDR_ARRAY_MODE, 8'h08);
		apb(1'b1, CCA_ADDR_COUNTER_LOW, 8'hF0);
		apb(1'b1, CCA_ADDR_COUNTER_HIGH, 8'h12);
		rdcnt(v1);
		rdcnt(v2);
		check({15'h0000, (v1 - 16'h12F0) < 16'h0014}, 16'h0001);
		check(v2 - v1, 16'h0006);
		// Every timebase code
		for (int k = 0; k < 6; k++) begin
			apb(1'b1, CCA_ADDR_ARRAY_MODE, {4'h0, 3'(k), 1'b0});
			apb(1'b1, CCA_ADDR_COUNTER_HIGH, 8'h00);
			apb(1'b1, CCA_ADDR_COUNTER_LOW, 8'h00);
			repeat (240) @(posedge core_clk);
			rdcnt(v1);
			check({15'h0000, near(v1, ticks(k, 242))}, 16'h0001);
		end
		// Idle suspend on, then off
		apb(1'b1, CCA_ADDR_ARRAY_MODE, 8'h88);
		cpu_idle <= 1'b1;
		rdcnt(v1);
		repeat (20) @(posedge core_clk);
		rdcnt(v2);
		check(v2, v1);
		apb(1'b1, CCA_ADDR_ARRAY_MODE, 8'h08);
		rdcnt(v1);
		rdcnt(v2);
		check(v2 - v1, 16'h0006);
		cpu_idle <= 1'b0;
		// Wrap, sticky flag, interrupt gating
		apb(1'b1, CCA_ADDR_COUNTER_HIGH, 8'hFF);
		apb(1'b1, CCA_ADDR_COUNTER_LOW, 8'hF0);
		repeat (30) @(posedge core_clk);
		apb(1'b0, CCA_ADDR_ARRAY_CONTROL, 8'h00);
		check({15'h0000, rd[CCA_AC_OVF_FLAG]}, 16'h0001);
		apb(1'b1, CCA_ADDR_ARRAY_MODE, 8'h09);
		for (int j = 0; j < 4; j++) begin
			global_irq_enable <= j[0];
			array_irq_enable <= j[1];
			repeat (3) @(posedge core_clk);
			check({15'h0000, irq_request}, 16'(j == 3));
		end
		apb(1'b0, CCA_ADDR_ARRAY_CONTROL, 8'h00);
		check({15'h0000, rd[CCA_AC_OVF_FLAG]}, 16'h0001);
		apb(1'b1, CCA_ADDR_ARRAY_CONTROL, 8'h7F);
		apb(1'b0, CCA_ADDR_ARRAY_CONTROL, 8'h00);
		check(rd[15:0], 16'h0000);
		// Compare modes per module; module 1 toggles its pin
		for (int n = 0; n < 3; n++) begin
			mode = (n == 1) ? 8'h4D : 8'h49;
			apb(1'b1, at(CCA_ADDR_MODULE_MODE, n), mode);
			rdcnt(v1);
			cap = v1 + 16'h0040 + 16'($random(seed) & 32'h0000_003F);
			apb(1'b1, at(CCA_ADDR_COMPARE_LOW, n), cap[7:0]);
			apb(1'b0, at(CCA_ADDR_MODULE_MODE, n), 8'h00);
			check(rd[15:0], {8'h00, mode & 8'hBF});
			apb(1'b1, at(CCA_ADDR_COMPARE_HIGH, n), cap[15:8]);
			apb(1'b0, at(CCA_ADDR_MODULE_MODE, n), 8'h00);
			check(rd[15:0], {8'h00, mode});
			check({15'h0000, pin_oe[n]}, 16'(n == 1));
			lvl = pin_out[n];
			repeat (160) @(posedge core_clk);
			apb(1'b0, CCA_ADDR_ARRAY_CONTROL, 8'h00);
			check(rd[15:0], 16'(1 << n));
			check({15'h0000, irq_request}, 16'h0001);
			if (n == 1) begin
				check({15'h0000, pin_out[n]}, {15'h0000, ~lvl});
			end
			apb(1'b1, at(CCA_ADDR_MODULE_MODE, n), 8'h00);
			apb(1'b1, CCA_ADDR_ARRAY_CONTROL, 8'h00);
		end
		// Capture edge kinds on module 0: fall, rise, both
		for (int k = 1; k < 4; k++) begin
			apb(1'b1, CCA_ADDR_MODULE_MODE, {2'b00, 2'(k), 4'h0});
			rdcnt(v1);
			want_pin[0] <= 1'b1;
			repeat (8) @(posedge core_clk);
			apb(1'b0, CCA_ADDR_ARRAY_CONTROL, 8'h00);
			check({15'h0000, rd[0]}, {15'h0000, k[1]});
			if (k[1]) begin
				apb(1'b0, CCA_ADDR_COMPARE_LOW, 8'h00);
				cap[7:0] = rd[7:0];
				apb(1'b0, CCA_ADDR_COMPARE_HIGH, 8'h00);
				cap[15:8] = rd[7:0];
				check({15'h0000, slverr}, 16'h0000);
				check({15'h0000, (cap - v1) < 16'h0010}, 16'h0001);
			end
			apb(1'b1, CCA_ADDR_ARRAY_CONTROL, 8'h00);
			want_pin[0] <= 1'b0;
			repeat (8) @(posedge core_clk);
			apb(1'b0, CCA_ADDR_ARRAY_CONTROL, 8'h00);
			check({15'h0000, rd[0]}, {15'h0000, k[0]});
			apb(1'b1, CCA_ADDR_ARRAY_CONTROL, 8'h00);
		end
		give_verdict();
	end
endmodule
